// ---- sample_flag_embedding_test.sv ----
// self-checking bench for the sample flag embedding top
`include "sfe_consts.vh"
module sample_flag_embedding_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic I_CLK, I_ARST_N, I_SMP_VALID, I_EIGHT_BIT, I_TRIGGER_INPUT_PAIR;
    logic [15:0] I_SMP_A0, I_SMP_A1, I_SMP_B0, I_SMP_B1;
    logic [7:0] I_AWADDR, I_ARADDR;
    logic [31:0] I_WDATA;
    logic [3:0] I_WSTRB;
    logic I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
    wire O_OUT_VALID, O_IRQ, O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
    wire O_CHAN_A_HIGH_FLAG_PIN, O_CHAN_A_LOW_FLAG_PIN;
    wire O_CHAN_B_HIGH_FLAG_PIN, O_CHAN_B_LOW_FLAG_PIN;
    wire [15:0] O_OUT_A0, O_OUT_A1, O_OUT_B0, O_OUT_B1;
    wire [1:0] O_BRESP, O_RRESP;
    wire [31:0] O_RDATA;
    int miscompares, n_compared, beats, gdn, qrun, i, b;
    sfe_top #(.SW(16), .CNT_W(11)) i_dut (.*);
    sfe_rx_model i_rx (.i_clk(I_CLK), .i_arst_n(I_ARST_N), .i_valid(O_OUT_VALID),
        .i_word_i(O_OUT_A0), .i_word_q(O_OUT_A1), .o_beats(beats), .o_gain_down(gdn),
        .o_quiet_run(qrun));
    initial begin
        I_CLK = 1'b0;
        forever #5 I_CLK = ~I_CLK;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_compared++;
        if (got !== ex) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic hang();
        miscompares++;
        final_report();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge I_CLK);
    endtask
    // each valid dropped only at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge I_CLK);
        I_AWADDR <= a;
        I_WDATA <= d;
        I_AWVALID <= 1'b1;
        I_WVALID <= 1'b1;
        I_BREADY <= 1'b1;
        repeat (50) begin
            @(posedge I_CLK);
            if (O_AWREADY) I_AWVALID <= 1'b0;
            if (O_WREADY) I_WVALID <= 1'b0;
            if (O_BVALID) break;
        end
        if (!O_BVALID) hang();
        I_BREADY <= 1'b0;
        chk("bresp", er, O_BRESP);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
        @(posedge I_CLK);
        I_ARADDR <= a;
        I_ARVALID <= 1'b1;
        I_RREADY <= 1'b1;
        repeat (50) begin
            @(posedge I_CLK);
            if (O_ARREADY) I_ARVALID <= 1'b0;
            if (O_RVALID) break;
        end
        if (!O_RVALID) hang();
        I_RREADY <= 1'b0;
        chk("rdata", ex, O_RDATA);
        chk("rresp", er, O_RRESP);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(`SFE_REG_CTRL, 32'h0, `SFE_RESP_OKAY);
        rd(`SFE_REG_THRESH, 32'h40e4, `SFE_RESP_OKAY);
        rd(`SFE_REG_STATUS, 32'h0, `SFE_RESP_OKAY);
        rd(`SFE_REG_IRQ_EN, 32'h0, `SFE_RESP_OKAY);
        rd(`SFE_REG_IRQ_CLR, 32'h0, `SFE_RESP_OKAY);
        rd(8'h40, 32'h0, `SFE_RESP_SLVERR);
        wr(8'h40, 32'hffff, `SFE_RESP_SLVERR);
    endtask
    task automatic t_chan();
        I_SMP_A1 <= 16'h3330;
        wr(`SFE_REG_CTRL, 32'h0, `SFE_RESP_OKAY);
        cyc(6);
        chk("dual lane1", 16'h0, O_OUT_A1);
        wr(`SFE_REG_CTRL, 32'h2000, `SFE_RESP_OKAY);
        cyc(6);
        chk("single lane1", 12'h333, O_OUT_A1[15:4]);
        b = beats;
        cyc(20);
        chk("beats", 20, beats - b);
    endtask
    task automatic t_trig();
        int n;
        wr(`SFE_REG_CTRL, 32'h1000, `SFE_RESP_OKAY);
        I_SMP_A0 <= 16'h1230;
        I_SMP_B0 <= 16'hfed0;
        cyc(6);
        chk("trig low a", 12'h122, O_OUT_A0[15:4]);
        chk("trig low b", 12'hfec, O_OUT_B0[15:4]);
        I_SMP_A0 <= 16'h1560;
        I_TRIGGER_INPUT_PAIR <= 1'b1;
        for (n = 0; n < 20 && O_OUT_A0[15:5] !== 11'h0ab; n++) @(posedge I_CLK);
        if (n == 20) hang();
        chk("trig aligned", 1, O_OUT_A0[4]);
        cyc(4);
        chk("irq masked", 0, O_IRQ);
        rd(`SFE_REG_STATUS, 32'h10, `SFE_RESP_OKAY);
        wr(`SFE_REG_IRQ_EN, 32'h10, `SFE_RESP_OKAY);
        cyc(3);
        chk("irq", 1, O_IRQ);
        wr(`SFE_REG_IRQ_CLR, 32'h10, `SFE_RESP_OKAY);
        cyc(3);
        chk("irq cleared", 0, O_IRQ);
        rd(`SFE_REG_STATUS, 32'h0, `SFE_RESP_OKAY);
        I_EIGHT_BIT <= 1'b1;
        I_TRIGGER_INPUT_PAIR <= 1'b0;
        cyc(6);
        chk("eight bit", 8'h14, O_OUT_A0[15:8]);
        I_EIGHT_BIT <= 1'b0;
    endtask
    // full scale on a, half scale on b, every decimating format
    task automatic t_emb();
        I_SMP_A0 <= 16'h7ff0;
        I_SMP_B0 <= 16'h4000;
        for (i = 9; i <= 16; i++) begin
            wr(`SFE_REG_CTRL, i, `SFE_RESP_OKAY);
            cyc(8);
            chk("i flag", i != 12, O_OUT_A0[0]);
            chk("q flag", 1, O_OUT_A1[0]);
            chk("b flag", 0, O_OUT_B0[0]);
            chk("b q flag", 1, O_OUT_B1[0]);
            chk("upper15", 15'h3ff8, O_OUT_A0[15:1]);
        end
        b = gdn;
        cyc(10);
        chk("gain down", 10, gdn - b);
        I_SMP_A0 <= 16'h4000;
        cyc(8);
        chk("mid i", 0, O_OUT_A0[0]);
        chk("mid q", 1, O_OUT_A1[0]);
        wr(`SFE_REG_THRESH, 32'h90e4, `SFE_RESP_OKAY);
        cyc(8);
        chk("raised low thr", 0, O_OUT_A1[0]);
        b = qrun;
        cyc(10);
        chk("quiet run", b + 10, qrun);
    endtask
    // one hit sample, then watch the embedded flag age out
    task automatic t_win(input logic [2:0] nset, input logic [7:0] md, input int at,
        input logic ex);
        wr(`SFE_REG_CTRL, {21'h0, nset, md}, `SFE_RESP_OKAY);
        I_SMP_A0 <= 16'h0;
        cyc(12);
        I_SMP_A0 <= 16'h7ff0;
        I_SMP_B0 <= 16'h8000;
        cyc(1);
        I_SMP_A0 <= 16'h0;
        I_SMP_B0 <= 16'h0;
        cyc(at);
        chk("window flag", ex, O_OUT_A0[0]);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {I_ARST_N, I_SMP_VALID, I_EIGHT_BIT, I_TRIGGER_INPUT_PAIR} = 4'h0;
        {I_SMP_A0, I_SMP_A1, I_SMP_B0, I_SMP_B1} = 64'h0;
        {I_AWADDR, I_ARADDR, I_WDATA} = 48'h0;
        {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = 5'h0;
        I_WSTRB = 4'hf;
        repeat (12) @(posedge I_CLK);
        I_ARST_N <= 1'b1;
        @(posedge I_CLK);
        I_SMP_VALID <= 1'b1;
        t_regs();
        t_chan();
        t_trig();
        t_emb();
        t_win(3'd3, 8'h0a, 5, 1'b1);
        t_win(3'd3, 8'h0a, 20, 1'b0);
        t_win(3'd0, 8'h0a, 8, 1'b0);
        t_win(3'd2, 8'h09, 9, 1'b1);
        t_win(3'd7, 8'h09, 200, 1'b1);
        final_report();
    end
endmodule

// ---- sfe_consts.vh ----
// constants for the sample flag embedding block
`ifndef SFE_CONSTS_VH
`define SFE_CONSTS_VH
// axi4-lite register byte offsets
`define SFE_REG_CTRL 8'h00
`define SFE_REG_THRESH 8'h04
`define SFE_REG_STATUS 8'h08
`define SFE_REG_IRQ_CLR 8'h0c
`define SFE_REG_IRQ_EN 8'h10
// ctrl field positions
`define SFE_CTRL_MODE_LSB 0
`define SFE_CTRL_MODE_MSB 4
`define SFE_CTRL_WIN_LSB 8
`define SFE_CTRL_WIN_MSB 10
`define SFE_CTRL_TRIG_EN 12
`define SFE_CTRL_SINGLE 13
// thresh field positions
`define SFE_THR_HIGH_LSB 0
`define SFE_THR_HIGH_MSB 7
`define SFE_THR_LOW_LSB 8
`define SFE_THR_LOW_MSB 15
// reset values
`define SFE_CTRL_RST 32'h0000_0000
`define SFE_THR_HIGH_RST 8'he4
`define SFE_THR_LOW_RST 8'h40
// link format codes
`define SFE_MODE_REAL_DEC 5'h09
`define SFE_MODE_CPLX_LO 5'h0a
`define SFE_MODE_CPLX_HI 5'h10
`define SFE_MODE_CPLX_SKIP 5'h0c
// axi responses
`define SFE_RESP_OKAY 2'b00
`define SFE_RESP_SLVERR 2'b10
// status bits
`define SFE_ST_A_HIGH 0
`define SFE_ST_A_LOW 1
`define SFE_ST_B_HIGH 2
`define SFE_ST_B_LOW 3
`define SFE_ST_TRIG 4
`define SFE_ST_W 5
`endif

// ---- sfe_flag_window.v ----
// threshold flag with hold window, one channel and one threshold
module sfe_flag_window #(
    parameter CNT_W = 11
) (
    // clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // sample side
    input wire i_valid,
    input wire [7:0] i_mag,
    input wire [7:0] i_thresh,
    input wire [CNT_W-1:0] i_window,
    // flag
    output reg o_flag
);
    reg [CNT_W-1:0] cnt_reg;
    wire hit;

    assign hit = i_valid && (i_mag >= i_thresh); // R17

    // flag holds for the window length counted from the last hit
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_reg <= {CNT_W{1'b0}};
            o_flag <= 1'b0;
        end else if (hit) begin
            cnt_reg <= i_window - {{(CNT_W-1){1'b0}}, 1'b1}; // R4
            o_flag <= 1'b1;
        end else if (i_valid) begin
            if (cnt_reg != {CNT_W{1'b0}}) begin
                cnt_reg <= cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
            end else begin
                o_flag <= 1'b0; // R17
            end
        end
    end
endmodule

// ---- sfe_rx_model.sv ----
// downstream receiver model: counts beats and watches embedded flags
module sfe_rx_model (
    // clock and reset
    input logic i_clk,
    input logic i_arst_n,
    // sample lanes
    input logic i_valid,
    input logic [15:0] i_word_i,
    input logic [15:0] i_word_q,
    // beat count and gain hints
    output int o_beats,
    output int o_gain_down,
    output int o_quiet_run
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_beats <= 0;
            o_gain_down <= 0;
            o_quiet_run <= 0;
        end else if (i_valid) begin
            o_beats <= o_beats + 1;
            // near full scale: back the gain off
            if (i_word_i[0]) o_gain_down <= o_gain_down + 1;
            // long quiet run calls for more gain
            o_quiet_run <= i_word_q[0] ? 0 : o_quiet_run + 1;
        end
    end
endmodule

// ---- sfe_top.v ----
// sample flag embedding: threshold and trigger marking in output samples
`include "sfe_consts.vh"

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1: real decimation: high flag on even samples, low on odd, window 2^(n+1).
// R2: complex modes except twelve: high flag in I samples, window 2^n.
// R3: complex modes: low flag in Q samples, same window as I.
// R4: window length comes from the programmed window setting.
// R5: software should set the high threshold near full scale, e.g. 228.
// R6: downstream watches the low flag, e.g. threshold 64, to raise gain.
// R7: trigger enable replaces 12-bit sample lsb with trigger, upper 11 kept.
// R8: trigger bit has the same pipeline latency as the samples.
// R9: in 8-bit modes the trigger rides in the lsb of each sample.
// R10: trigger may be asynchronous; sampled with the analog input.
// R11: software must not use trigger marking in decimating modes.
// R12: dual-channel mode takes one sample per clock rising edge.
// R13: single-channel mode takes two samples per clock, both edges.
// R14: one clock drives sampling, processing and serializer side.
// R15: sysref source may be pulse or periodic, captured on the right edge.
// R16: periodic sysref = R*fclk/(10*F*K*n).
// R17: flag set when upper 8 abs bits reach threshold within window.
// R18: complex modes: flag is lsb beside upper fifteen sample bits.
module sfe_top #(
    parameter SW = 16,
    parameter CNT_W = 11
) (
    // clock and reset
    input wire I_CLK,
    input wire I_ARST_N,
    // converter samples: a0/b0 rising edge, a1 falling edge in single mode
    input wire I_SMP_VALID,
    input wire [SW-1:0] I_SMP_A0,
    input wire [SW-1:0] I_SMP_A1,
    input wire [SW-1:0] I_SMP_B0,
    input wire [SW-1:0] I_SMP_B1,
    input wire I_EIGHT_BIT,
    input wire I_TRIGGER_INPUT_PAIR,
    // marked samples to the link
    output reg O_OUT_VALID,
    output reg [SW-1:0] O_OUT_A0,
    output reg [SW-1:0] O_OUT_A1,
    output reg [SW-1:0] O_OUT_B0,
    output reg [SW-1:0] O_OUT_B1,
    // flag pins
    output reg O_CHAN_A_HIGH_FLAG_PIN,
    output reg O_CHAN_A_LOW_FLAG_PIN,
    output reg O_CHAN_B_HIGH_FLAG_PIN,
    output reg O_CHAN_B_LOW_FLAG_PIN,
    output reg O_IRQ,
    // axi4-lite write
    input wire [7:0] I_AWADDR,
    input wire I_AWVALID,
    output reg O_AWREADY,
    input wire [31:0] I_WDATA,
    input wire [3:0] I_WSTRB,
    input wire I_WVALID,
    output reg O_WREADY,
    output reg [1:0] O_BRESP,
    output reg O_BVALID,
    input wire I_BREADY,
    // axi4-lite read
    input wire [7:0] I_ARADDR,
    input wire I_ARVALID,
    output reg O_ARREADY,
    output reg [31:0] O_RDATA,
    output reg [1:0] O_RRESP,
    output reg O_RVALID,
    input wire I_RREADY
);
    // upper 8 bits of the 11-bit magnitude of the 12-bit sample (samples are left aligned)
    function [7:0] mag8;
        input [SW-1:0] s;
        reg [11:0] v;
        begin
            v = s[SW-1:SW-12];
            if (v[11]) begin
                v = (v == 12'h800) ? 12'h7ff : (~v + 12'h001);
            end
            mag8 = v[10:3];
        end
    endfunction

    function [SW-1:0] put_lsb;
        input [SW-1:0] s;
        input b;
        begin
            put_lsb = {s[SW-1:1], b};
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // registers
    reg [31:0] ctrl_reg;
    reg [7:0] thr_high_reg;
    reg [7:0] thr_low_reg;
    reg [`SFE_ST_W-1:0] status_reg;
    reg [`SFE_ST_W-1:0] irq_en_reg;
    reg [7:0] awaddr_reg;
    reg aw_held_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    reg w_held_reg;
    reg trig_s1_reg;
    reg trig_s2_reg;
    reg trig_d_reg;
    reg [`SFE_ST_W-1:0] clr_next;
    reg [`SFE_ST_W-1:0] set_next;
    reg [SW-1:0] a0_next;
    reg [SW-1:0] a1_next;
    reg [SW-1:0] b0_next;
    reg [SW-1:0] b1_next;
    reg [31:0] rd_next;
    reg [1:0] rresp_next;

    wire [4:0] mode = ctrl_reg[`SFE_CTRL_MODE_MSB:`SFE_CTRL_MODE_LSB];
    wire [2:0] win_set = ctrl_reg[`SFE_CTRL_WIN_MSB:`SFE_CTRL_WIN_LSB];
    wire trig_en = ctrl_reg[`SFE_CTRL_TRIG_EN];
    wire single_mode = ctrl_reg[`SFE_CTRL_SINGLE];
    wire real_dec = (mode == `SFE_MODE_REAL_DEC);
    wire cplx = (mode >= `SFE_MODE_CPLX_LO) && (mode <= `SFE_MODE_CPLX_HI);
    wire cplx_flag = cplx && (mode != `SFE_MODE_CPLX_SKIP); // R2
    wire decim = real_dec || cplx;
    wire [CNT_W-1:0] win_len = real_dec ?
        ({{(CNT_W-1){1'b0}}, 1'b1} << ({1'b0, win_set} + 4'h1)) :
        ({{(CNT_W-1){1'b0}}, 1'b1} << win_set); // R1 R2 R4

    //////////////////////////////////////////////////////////////////////////
    // threshold flags, one per channel and threshold
    wire fa_hi, fa_lo, fb_hi, fb_lo;
    wire [7:0] mag_a = mag8(I_SMP_A0);
    wire [7:0] mag_b = mag8(I_SMP_B0);

    sfe_flag_window #(.CNT_W(CNT_W)) u_fa_hi (
        .i_clk(I_CLK), .i_arst_n(I_ARST_N), .i_valid(I_SMP_VALID),
        .i_mag(mag_a), .i_thresh(thr_high_reg), .i_window(win_len),
        .o_flag(fa_hi));
    sfe_flag_window #(.CNT_W(CNT_W)) u_fa_lo (
        .i_clk(I_CLK), .i_arst_n(I_ARST_N), .i_valid(I_SMP_VALID),
        .i_mag(mag_a), .i_thresh(thr_low_reg), .i_window(win_len),
        .o_flag(fa_lo));
    sfe_flag_window #(.CNT_W(CNT_W)) u_fb_hi (
        .i_clk(I_CLK), .i_arst_n(I_ARST_N), .i_valid(I_SMP_VALID),
        .i_mag(mag_b), .i_thresh(thr_high_reg), .i_window(win_len),
        .o_flag(fb_hi));
    sfe_flag_window #(.CNT_W(CNT_W)) u_fb_lo (
        .i_clk(I_CLK), .i_arst_n(I_ARST_N), .i_valid(I_SMP_VALID),
        .i_mag(mag_b), .i_thresh(thr_low_reg), .i_window(win_len),
        .o_flag(fb_lo));

    //////////////////////////////////////////////////////////////////////////
    // trigger sync costs two stages, so samples and valid wait two stages too
    reg [4*SW:0] smp_p_reg;
    reg [SW-1:0] a0_d_reg;
    reg [SW-1:0] a1_d_reg;
    reg [SW-1:0] b0_d_reg;
    reg [SW-1:0] b1_d_reg;
    reg vld_d_reg;
    reg ea_hi_reg;
    reg ea_lo_reg;
    reg eb_hi_reg;
    reg eb_lo_reg;

    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            trig_s1_reg <= 1'b0;
            trig_s2_reg <= 1'b0;
            trig_d_reg <= 1'b0;
            smp_p_reg <= {(4*SW+1){1'b0}};
            a0_d_reg <= {SW{1'b0}};
            a1_d_reg <= {SW{1'b0}};
            b0_d_reg <= {SW{1'b0}};
            b1_d_reg <= {SW{1'b0}};
            vld_d_reg <= 1'b0;
            ea_hi_reg <= 1'b0;
            ea_lo_reg <= 1'b0;
            eb_hi_reg <= 1'b0;
            eb_lo_reg <= 1'b0;
        end else begin
            trig_s1_reg <= I_TRIGGER_INPUT_PAIR; // R10
            trig_s2_reg <= trig_s1_reg;
            trig_d_reg <= trig_s2_reg;
            smp_p_reg <= {I_SMP_VALID, I_SMP_B1, I_SMP_B0, I_SMP_A1, I_SMP_A0}; // R8
            a0_d_reg <= smp_p_reg[SW-1:0];
            a1_d_reg <= smp_p_reg[2*SW-1:SW];
            b0_d_reg <= smp_p_reg[3*SW-1:2*SW];
            b1_d_reg <= smp_p_reg[4*SW-1:3*SW];
            vld_d_reg <= smp_p_reg[4*SW];
            ea_hi_reg <= fa_hi;
            ea_lo_reg <= fa_lo;
            eb_hi_reg <= fb_hi;
            eb_lo_reg <= fb_lo;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // output marking: lane 0 is even / in-phase, lane 1 odd / quadrature
    always @* begin
        a0_next = a0_d_reg;
        a1_next = single_mode ? a1_d_reg : {SW{1'b0}}; // R12 R13 R14
        b0_next = b0_d_reg;
        b1_next = b1_d_reg;
        if (real_dec || cplx_flag) begin
            a0_next = put_lsb(a0_d_reg, ea_hi_reg); // R1 R2 R18
            b0_next = put_lsb(b0_d_reg, eb_hi_reg); // R1 R2 R18
        end
        if (decim) begin
            a1_next = put_lsb(a1_d_reg, ea_lo_reg); // R1 R3 R18
            b1_next = put_lsb(b1_d_reg, eb_lo_reg); // R1 R3 R18
        end else if (trig_en) begin
            if (I_EIGHT_BIT) begin
                a0_next[SW-8] = trig_s2_reg; // R9
                b0_next[SW-8] = trig_s2_reg; // R9
                if (single_mode) begin
                    a1_next[SW-8] = trig_s2_reg; // R9
                end
            end else begin
                a0_next[SW-12] = trig_s2_reg; // R7 R8
                b0_next[SW-12] = trig_s2_reg; // R7 R8
                if (single_mode) begin
                    a1_next[SW-12] = trig_s2_reg; // R7 R13
                end
            end
        end
    end

    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_OUT_VALID <= 1'b0;
            O_OUT_A0 <= {SW{1'b0}};
            O_OUT_A1 <= {SW{1'b0}};
            O_OUT_B0 <= {SW{1'b0}};
            O_OUT_B1 <= {SW{1'b0}};
            O_CHAN_A_HIGH_FLAG_PIN <= 1'b0;
            O_CHAN_A_LOW_FLAG_PIN <= 1'b0;
            O_CHAN_B_HIGH_FLAG_PIN <= 1'b0;
            O_CHAN_B_LOW_FLAG_PIN <= 1'b0;
        end else begin
            O_OUT_VALID <= vld_d_reg;
            O_OUT_A0 <= a0_next;
            O_OUT_A1 <= a1_next;
            O_OUT_B0 <= b0_next;
            O_OUT_B1 <= b1_next;
            O_CHAN_A_HIGH_FLAG_PIN <= fa_hi; // R17
            O_CHAN_A_LOW_FLAG_PIN <= fa_lo;
            O_CHAN_B_HIGH_FLAG_PIN <= fb_hi;
            O_CHAN_B_LOW_FLAG_PIN <= fb_lo;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // axi4-lite slave: address and data caught in either order
    wire wr_go = aw_held_reg && w_held_reg && !O_BVALID;
    wire trig_rise = trig_s2_reg && !trig_d_reg;

    always @* begin
        set_next = {`SFE_ST_W{1'b0}};
        set_next[`SFE_ST_A_HIGH] = fa_hi;
        set_next[`SFE_ST_A_LOW] = fa_lo;
        set_next[`SFE_ST_B_HIGH] = fb_hi;
        set_next[`SFE_ST_B_LOW] = fb_lo;
        set_next[`SFE_ST_TRIG] = trig_rise;
        clr_next = {`SFE_ST_W{1'b0}};
        if (wr_go && awaddr_reg == `SFE_REG_IRQ_CLR && wstrb_reg[0]) begin
            clr_next = wdata_reg[`SFE_ST_W-1:0];
        end
    end

    always @* begin
        rd_next = 32'h0000_0000;
        rresp_next = `SFE_RESP_OKAY;
        case (I_ARADDR)
            `SFE_REG_CTRL: begin
                rd_next = ctrl_reg;
            end
            `SFE_REG_THRESH: begin
                rd_next = {16'h0000, thr_low_reg, thr_high_reg};
            end
            `SFE_REG_STATUS: begin
                rd_next = {{(32-`SFE_ST_W){1'b0}}, status_reg};
            end
            `SFE_REG_IRQ_CLR: begin
                rd_next = 32'h0000_0000;
            end
            `SFE_REG_IRQ_EN: begin
                rd_next = {{(32-`SFE_ST_W){1'b0}}, irq_en_reg};
            end
            default: begin
                rresp_next = `SFE_RESP_SLVERR;
            end
        endcase
    end

    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ctrl_reg <= `SFE_CTRL_RST;
            thr_high_reg <= `SFE_THR_HIGH_RST;
            thr_low_reg <= `SFE_THR_LOW_RST;
            status_reg <= {`SFE_ST_W{1'b0}};
            irq_en_reg <= {`SFE_ST_W{1'b0}};
            awaddr_reg <= 8'h00;
            aw_held_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            w_held_reg <= 1'b0;
            O_AWREADY <= 1'b0;
            O_WREADY <= 1'b0;
            O_BVALID <= 1'b0;
            O_BRESP <= `SFE_RESP_OKAY;
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= 32'h0000_0000;
            O_RRESP <= `SFE_RESP_OKAY;
            O_IRQ <= 1'b0;
        end else begin
            // set wins over a clear in the same cycle
            status_reg <= (status_reg & ~clr_next) | set_next;
            O_IRQ <= |(status_reg & irq_en_reg);
            O_AWREADY <= !aw_held_reg && !O_AWREADY && I_AWVALID;
            O_WREADY <= !w_held_reg && !O_WREADY && I_WVALID;
            if (O_AWREADY && I_AWVALID) begin
                awaddr_reg <= I_AWADDR;
                aw_held_reg <= 1'b1;
            end
            if (O_WREADY && I_WVALID) begin
                wdata_reg <= I_WDATA;
                wstrb_reg <= I_WSTRB;
                w_held_reg <= 1'b1;
            end
            if (wr_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                O_BVALID <= 1'b1;
                O_BRESP <= `SFE_RESP_OKAY;
                case (awaddr_reg)
                    `SFE_REG_CTRL: begin
                        if (wstrb_reg[0]) ctrl_reg[7:0] <= wdata_reg[7:0];
                        if (wstrb_reg[1]) ctrl_reg[15:8] <= wdata_reg[15:8];
                    end
                    `SFE_REG_THRESH: begin
                        if (wstrb_reg[0]) thr_high_reg <= wdata_reg[7:0];
                        if (wstrb_reg[1]) thr_low_reg <= wdata_reg[15:8];
                    end
                    `SFE_REG_IRQ_EN: begin
                        if (wstrb_reg[0]) irq_en_reg <= wdata_reg[`SFE_ST_W-1:0];
                    end
                    `SFE_REG_IRQ_CLR: begin
                        O_BRESP <= `SFE_RESP_OKAY;
                    end
                    default: begin
                        O_BRESP <= `SFE_RESP_SLVERR;
                    end
                endcase
            end else if (O_BVALID && I_BREADY) begin
                O_BVALID <= 1'b0;
            end
            O_ARREADY <= !O_ARREADY && !O_RVALID && I_ARVALID;
            if (O_ARREADY && I_ARVALID) begin
                O_RVALID <= 1'b1;
                O_RDATA <= rd_next;
                O_RRESP <= rresp_next;
            end else if (O_RVALID && I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end
endmodule

// ---- sfe_top_sva.sv ----
// port-level assertions for the sample flag embedding top
`include "sfe_consts.vh"
module sfe_chk #(
    parameter SW = 16,
    parameter CNT_W = 11
) (
    // clock, reset, samples
    input wire I_CLK,
    input wire I_ARST_N,
    input wire I_SMP_VALID,
    input wire [SW-1:0] I_SMP_A0,
    input wire [SW-1:0] I_SMP_B0,
    input wire O_OUT_VALID,
    input wire [SW-1:0] O_OUT_A0,
    input wire [SW-1:0] O_OUT_B0,
    input wire O_CHAN_A_HIGH_FLAG_PIN,
    input wire O_CHAN_A_LOW_FLAG_PIN,
    input wire O_CHAN_B_HIGH_FLAG_PIN,
    input wire O_CHAN_B_LOW_FLAG_PIN,
    input wire O_IRQ,
    // bus
    input wire O_BVALID,
    input wire I_BREADY,
    input wire O_RVALID,
    input wire I_RREADY,
    input wire [31:0] O_RDATA,
    input wire [1:0] O_RRESP
);
    default clocking dc @(posedge I_CLK);
    endclocking
    default disable iff (!I_ARST_N);
    property p_val_lat;
        O_OUT_VALID == $past(I_SMP_VALID, 3);
    endproperty
    a_val_lat: assert property (p_val_lat) else $error("valid latency");
    property p_a_upper;
        O_OUT_VALID |-> O_OUT_A0[SW-1:9] == $past(I_SMP_A0[SW-1:9], 3);
    endproperty
    a_a_upper: assert property (p_a_upper) else $error("lane a upper bits");
    property p_b_upper;
        O_OUT_VALID |-> O_OUT_B0[SW-1:9] == $past(I_SMP_B0[SW-1:9], 3);
    endproperty
    a_b_upper: assert property (p_b_upper) else $error("lane b upper bits");
    property p_a_full;
        I_SMP_VALID && I_SMP_A0[SW-1:SW-12] == 12'h7ff |->
            ##[1:3] O_CHAN_A_HIGH_FLAG_PIN && O_CHAN_A_LOW_FLAG_PIN;
    endproperty
    a_a_full: assert property (p_a_full) else $error("channel a flags");
    property p_b_full;
        I_SMP_VALID && I_SMP_B0[SW-1:SW-12] == 12'h800 |->
            ##[1:3] O_CHAN_B_HIGH_FLAG_PIN && O_CHAN_B_LOW_FLAG_PIN;
    endproperty
    a_b_full: assert property (p_b_full) else $error("channel b flags");
    property p_b_one;
        O_BVALID && I_BREADY |=> !O_BVALID;
    endproperty
    a_b_one: assert property (p_b_one) else $error("write response repeated");
    property p_r_one;
        O_RVALID && I_RREADY |=> !O_RVALID;
    endproperty
    a_r_one: assert property (p_r_one) else $error("read response repeated");
    property p_err_zero;
        O_RVALID && O_RRESP == `SFE_RESP_SLVERR |-> O_RDATA == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read not zero");
    c_err: cover property (O_RVALID && O_RRESP == `SFE_RESP_SLVERR);
    c_irq: cover property ($rose(O_IRQ));
    c_flag: cover property ($rose(O_CHAN_A_HIGH_FLAG_PIN));
endmodule
bind sfe_top sfe_chk #(.SW(SW), .CNT_W(CNT_W)) i_chk (.*);
